// >>> logic/hsc_entry_flags.sv
// Completion / cancellation flag pair for one kind of operator entry.
// Assumes single-cycle event pulses on the panel clock.
`timescale 1ns/1ps
module hsc_entry_flags
    import hsc_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    hsc_entry_if.flags ent
);

    logic done_q;
    logic done_d;
    logic cancel_q;
    logic cancel_d;

    // Events beat the software clear so none is lost
    always_comb begin
        done_d   = done_q;
        cancel_d = cancel_q;
        if (ent.done) begin
            done_d   = 1'b1;
            cancel_d = 1'b0;
        end else if (ent.cancel) begin
            done_d   = 1'b0;
            cancel_d = 1'b1;
        end else if (ent.start || ent.clear) begin
            done_d   = 1'b0;
            cancel_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_q   <= 1'b0;
            cancel_q <= 1'b0;
        end else begin
            done_q   <= done_d;
            cancel_q <= cancel_d;
        end
    end

    assign ent.flag_done   = done_q;
    assign ent.flag_cancel = cancel_q;

endmodule

// >>> logic/hsc_if.sv
// Carriers between the top and its two helpers.
// Assumes all three modules share one clock and synchronised reset.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
interface hsc_entry_if;
    logic start;
    logic done;
    logic cancel;
    logic clear;
    logic flag_done;
    logic flag_cancel;
    modport ctrl (output start, done, cancel, clear,
                  input  flag_done, flag_cancel);
    modport flags (input  start, done, cancel, clear,
                   output flag_done, flag_cancel);
endinterface

////////////////////////////////////////////////////////////////////////////
interface hsc_time_if;
    logic [15:0] month_year;
    logic [15:0] hour_day;
    logic [15:0] second_minute;
    logic        commit;
    logic [47:0] time_now;
    logic        loaded;
    modport ctrl (output month_year, hour_day, second_minute, commit,
                  input  time_now, loaded);
    modport clock (input  month_year, hour_day, second_minute, commit,
                   output time_now, loaded);
endinterface

// >>> logic/hsc_pkg.sv
// Constants for the operator-panel status and clock-set register bank.
// Assumes word-indexed registers on a 32-bit Avalon-MM slave.
package hsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned HSC_DATA_W   = 32;
    localparam int unsigned HSC_REG_W    = 16;
    localparam int unsigned HSC_BE_W     = 4;
    localparam int unsigned HSC_IDX_W    = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [3:0] HSC_IDX_ENTRY_CLEAR   = 4'h1;
    localparam logic [3:0] HSC_IDX_STATUS        = 4'h3;
    localparam logic [3:0] HSC_IDX_MONTH_YEAR    = 4'h4;
    localparam logic [3:0] HSC_IDX_HOUR_DAY      = 4'h5;
    localparam logic [3:0] HSC_IDX_SECOND_MINUTE = 4'h6;
    localparam logic [3:0] HSC_IDX_COMMIT        = 4'h7;
    localparam logic [3:0] HSC_IDX_IRQ_STATUS    = 4'h8;
    localparam logic [3:0] HSC_IDX_IRQ_MASK      = 4'h9;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned HSC_CLR_NUM_BIT     = 10;
    localparam int unsigned HSC_CLR_TXT_BIT     = 11;
    localparam int unsigned HSC_ST_NUM_DONE     = 0;
    localparam int unsigned HSC_ST_NUM_CANCEL   = 1;
    localparam int unsigned HSC_ST_BL_OFF       = 2;
    localparam int unsigned HSC_ST_RECIPE       = 4;
    localparam int unsigned HSC_ST_TXT_DONE     = 5;
    localparam int unsigned HSC_ST_TXT_CANCEL   = 6;
    localparam int unsigned HSC_COMMIT_BIT      = 15;
    localparam int unsigned HSC_LO_FIELD_LSB    = 0;
    localparam int unsigned HSC_HI_FIELD_LSB    = 8;

    // Interrupt status / mask layout
    localparam int unsigned HSC_IRQ_W           = 6;
    localparam int unsigned HSC_IRQ_NUM_DONE    = 0;
    localparam int unsigned HSC_IRQ_NUM_CANCEL  = 1;
    localparam int unsigned HSC_IRQ_BL_OFF      = 2;
    localparam int unsigned HSC_IRQ_RECIPE_END  = 3;
    localparam int unsigned HSC_IRQ_TXT_DONE    = 4;
    localparam int unsigned HSC_IRQ_TXT_CANCEL  = 5;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] HSC_STAGE_RST = 16'h0000;
    localparam logic [5:0]  HSC_IRQ_RST   = 6'h00;
    localparam logic [47:0] HSC_TIME_RST  = 48'h000101000000;

    typedef logic [7:0] hsc_bcd_t;

endpackage

// >>> logic/hsc_time_hold.sv
// Internal clock value, loaded only by a whole commit.
// Assumes commit is a one-cycle pulse from the register bank.
`timescale 1ns/1ps
module hsc_time_hold
    import hsc_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    hsc_time_if.clock  tm
);

    logic [47:0] time_q;
    logic        loaded_q;

    // Year, month, day, hour, minute, second in one edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            time_q   <= HSC_TIME_RST;
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= tm.commit;
            if (tm.commit) begin
                time_q <= {tm.month_year, tm.hour_day, tm.second_minute};
            end
        end
    end

    assign tm.time_now = time_q;
    assign tm.loaded   = loaded_q;

endmodule

// >>> logic/hsc_top.sv
// Status word and clock-set register bank of the operator panel.
// Assumes an Avalon-MM master and same-clock event inputs from the panel.
//
// What this block does
// - Numeric done flag sets on completion, clears on new entry or cancel.
// - Writing one to clear-word bit 10 clears both numeric flags.
// - Numeric cancel flag sets on cancel, clears on new entry or completion.
// - Backlight-off bit follows auto-off turning the lamp off, clears on.
// - Recipe bit reads one while recipe data transfers.
// - Text done flag sets on completion, clears on new entry or cancel.
// - Text cancel flag sets on cancel, clears on new entry or completion.
// - Writing one to clear-word bit 11 clears both text flags.
// - A one in commit bit 15 copies the staging words to the clock.
// - The commit loads all six time fields together.
// - Staging writes alone never change the running clock.
`timescale 1ns/1ps
module hsc_top
    import hsc_pkg::*;
#(
    parameter int unsigned ADDR_W = 6
)
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    // Avalon-MM slave, byte addressed
    input  wire logic [ADDR_W-1:0]     i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [HSC_DATA_W-1:0] i_avs_writedata,
    input  wire logic [HSC_BE_W-1:0]   i_avs_byteenable,
    output logic      [HSC_DATA_W-1:0] o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Panel events, one-cycle pulses
    input  wire logic                  i_num_start,
    input  wire logic                  i_num_done,
    input  wire logic                  i_num_cancel,
    input  wire logic                  i_txt_start,
    input  wire logic                  i_txt_done,
    input  wire logic                  i_txt_cancel,
    // Panel levels
    input  wire logic                  i_autooff_en,
    input  wire logic                  i_backlight_off,
    input  wire logic                  i_recipe_busy,
    // Internal clock value and interrupt request
    output logic      [47:0]           o_time_now,
    output logic                       o_time_loaded,
    output logic                       o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (ADDR_W < HSC_IDX_W + 2) begin : g_addr_chk
        $error("ADDR_W too small for the register map");
    end

    // Lanes 0 and 1 of a 32-bit bus carry each 16-bit word
    if (HSC_DATA_W != 32 || HSC_BE_W != 4) begin : g_bus_chk
        $error("Bus must be 32 bits in four lanes");
    end

    if (HSC_REG_W != 16 || HSC_IDX_W != 4) begin : g_reg_chk
        $error("Registers must be 16 bits, indices 4 bits");
    end

    if (HSC_IRQ_W > 8) begin : g_irq_chk
        $error("Interrupt bits must fit byte lane 0");
    end

    if (HSC_CLR_NUM_BIT < 8 || HSC_CLR_TXT_BIT < 8) begin : g_clr_chk
        $error("Clear bits must sit in byte lane 1");
    end

    if (HSC_COMMIT_BIT < 8 || HSC_COMMIT_BIT > 15) begin : g_cmt_chk
        $error("Commit bit must sit in byte lane 1");
    end

    if (HSC_ST_TXT_CANCEL >= HSC_REG_W) begin : g_st_chk
        $error("Status bits must fit one word");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    // Assert at once, release on the clock so all flops leave together
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire rst_b = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle on every access
    logic ack_q;
    logic ack_d;
    wire  req      = i_avs_read | i_avs_write;
    wire  wr_fire  = i_avs_write & ack_q;

    assign ack_d             = req & ~ack_q;
    assign o_avs_waitrequest = req & ~ack_q;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire [HSC_IDX_W-1:0] idx    = i_avs_address[HSC_IDX_W+1:2];
    // A shift, not a slice: legal even with no bits above the index
    wire                 in_map = ((i_avs_address >> (HSC_IDX_W + 2)) == '0)
                                  && (i_avs_address[1:0] == 2'b00);
    wire sel_clear  = in_map && (idx == HSC_IDX_ENTRY_CLEAR);
    wire sel_status = in_map && (idx == HSC_IDX_STATUS);
    wire sel_my     = in_map && (idx == HSC_IDX_MONTH_YEAR);
    wire sel_hd     = in_map && (idx == HSC_IDX_HOUR_DAY);
    wire sel_sm     = in_map && (idx == HSC_IDX_SECOND_MINUTE);
    wire sel_commit = in_map && (idx == HSC_IDX_COMMIT);
    wire sel_irq_st = in_map && (idx == HSC_IDX_IRQ_STATUS);
    wire sel_irq_mk = in_map && (idx == HSC_IDX_IRQ_MASK);

    // Byte lanes 0 and 1 carry the 16-bit registers
    wire [15:0] be_mask = {{8{i_avs_byteenable[1]}},
                           {8{i_avs_byteenable[0]}}};
    wire [15:0] wdata   = i_avs_writedata[15:0];

    // Control bits ride in lane 1, interrupt words in lane 0
    wire hi_wr = wr_fire & i_avs_byteenable[1];
    wire lo_wr = wr_fire & i_avs_byteenable[0];

    ////////////////////////////////////////////////////////////////////////
    // Entry flag pairs
    hsc_entry_if num_if ();
    hsc_entry_if txt_if ();

    assign num_if.start  = i_num_start;
    assign num_if.done   = i_num_done;
    assign num_if.cancel = i_num_cancel;
    assign num_if.clear  = hi_wr && sel_clear
                           && wdata[HSC_CLR_NUM_BIT];

    assign txt_if.start  = i_txt_start;
    assign txt_if.done   = i_txt_done;
    assign txt_if.cancel = i_txt_cancel;
    assign txt_if.clear  = hi_wr && sel_clear
                           && wdata[HSC_CLR_TXT_BIT];

    hsc_entry_flags u_num_flags (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .ent     (num_if.flags)
    );

    hsc_entry_flags u_txt_flags (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .ent     (txt_if.flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status word
    wire bl_auto_off = i_autooff_en & i_backlight_off;

    // Unassigned positions stay zero
    logic [15:0] status_word;
    always_comb begin
        status_word                    = 16'h0000;
        status_word[HSC_ST_NUM_DONE]   = num_if.flag_done;
        status_word[HSC_ST_NUM_CANCEL] = num_if.flag_cancel;
        status_word[HSC_ST_BL_OFF]     = bl_auto_off;
        status_word[HSC_ST_RECIPE]     = i_recipe_busy;
        status_word[HSC_ST_TXT_DONE]   = txt_if.flag_done;
        status_word[HSC_ST_TXT_CANCEL] = txt_if.flag_cancel;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock staging words
    logic [15:0] my_q;
    logic [15:0] hd_q;
    logic [15:0] sm_q;
    logic [15:0] my_d;
    logic [15:0] hd_d;
    logic [15:0] sm_d;

    wire wr_my = wr_fire && sel_my;
    wire wr_hd = wr_fire && sel_hd;
    wire wr_sm = wr_fire && sel_sm;

    assign my_d = wr_my ? ((my_q & ~be_mask) | (wdata & be_mask)) : my_q;
    assign hd_d = wr_hd ? ((hd_q & ~be_mask) | (wdata & be_mask)) : hd_q;
    assign sm_d = wr_sm ? ((sm_q & ~be_mask) | (wdata & be_mask)) : sm_q;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            my_q <= HSC_STAGE_RST;
            hd_q <= HSC_STAGE_RST;
            sm_q <= HSC_STAGE_RST;
        end else begin
            my_q <= my_d;
            hd_q <= hd_d;
            sm_q <= sm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commit: a pulse, so each written one loads exactly once
    logic commit_q;
    // Low bits are ignored rather than checked; software keeps them zero
    wire  commit_d = hi_wr && sel_commit
                     && wdata[HSC_COMMIT_BIT];

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            commit_q <= 1'b0;
        end else begin
            commit_q <= commit_d;
        end
    end

    hsc_time_if tm_if ();

    // Staging words reach the clock only through the commit
    assign tm_if.month_year    = my_q;
    assign tm_if.hour_day      = hd_q;
    assign tm_if.second_minute = sm_q;
    assign tm_if.commit        = commit_q;

    hsc_time_hold u_time (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .tm      (tm_if.clock)
    );

    assign o_time_now    = tm_if.time_now;
    assign o_time_loaded = tm_if.loaded;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events
    logic bl_off_q;
    logic recipe_q;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            bl_off_q <= 1'b0;
            recipe_q <= 1'b0;
        end else begin
            bl_off_q <= bl_auto_off;
            recipe_q <= i_recipe_busy;
        end
    end

    // Edges of the two live levels are interrupt events
    wire bl_rise     = bl_auto_off & ~bl_off_q;
    wire recipe_fall = recipe_q & ~i_recipe_busy;

    logic [HSC_IRQ_W-1:0] irq_evt;
    always_comb begin
        irq_evt                     = '0;
        irq_evt[HSC_IRQ_NUM_DONE]   = i_num_done;
        irq_evt[HSC_IRQ_NUM_CANCEL] = i_num_cancel;
        irq_evt[HSC_IRQ_BL_OFF]     = bl_rise;
        irq_evt[HSC_IRQ_RECIPE_END] = recipe_fall;
        irq_evt[HSC_IRQ_TXT_DONE]   = i_txt_done;
        irq_evt[HSC_IRQ_TXT_CANCEL] = i_txt_cancel;
    end

    logic [HSC_IRQ_W-1:0] irq_st_q;
    logic [HSC_IRQ_W-1:0] irq_st_d;
    logic [HSC_IRQ_W-1:0] irq_mk_q;
    logic [HSC_IRQ_W-1:0] irq_mk_d;

    wire [HSC_IRQ_W-1:0] irq_w1c =
        (lo_wr && sel_irq_st)
        ? wdata[HSC_IRQ_W-1:0] : '0;

    // Set wins over the write-one clear
    assign irq_st_d = (irq_st_q & ~irq_w1c) | irq_evt;
    assign irq_mk_d = (lo_wr && sel_irq_mk)
                      ? wdata[HSC_IRQ_W-1:0] : irq_mk_q;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_st_q <= HSC_IRQ_RST;
            irq_mk_q <= HSC_IRQ_RST;
        end else begin
            irq_st_q <= irq_st_d;
            irq_mk_q <= irq_mk_d;
        end
    end

    assign o_irq = |(irq_st_q & irq_mk_q);

    ////////////////////////////////////////////////////////////////////////
    // Read path, registered during the wait cycle
    logic [15:0] rd_word;
    always_comb begin
        if (sel_status) begin
            rd_word = status_word;
        end else if (sel_my) begin
            rd_word = my_q;
        end else if (sel_hd) begin
            rd_word = hd_q;
        end else if (sel_sm) begin
            rd_word = sm_q;
        end else if (sel_irq_st) begin
            rd_word = {{(16-HSC_IRQ_W){1'b0}}, irq_st_q};
        end else if (sel_irq_mk) begin
            rd_word = {{(16-HSC_IRQ_W){1'b0}}, irq_mk_q};
        end else begin
            // Clear and commit words read as zero, as does a hole
            rd_word = 16'h0000;
        end
    end

    logic [HSC_DATA_W-1:0] rdata_q;
    wire  [HSC_DATA_W-1:0] rdata_d = (i_avs_read && ack_d)
                                     ? {16'h0000, rd_word} : rdata_q;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_avs_readdata = rdata_q;

endmodule

// >>> verif/hmi_status_and_clock_set_tb_top.sv
// Self-checking bench for the status and clock-set register bank.
// Assumes the port checker is bound into the design by its own file.
`timescale 1ns/1ps
module hmi_status_and_clock_set_tb_top
    import hsc_pkg::*;
;
    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic [5:0]  adr       = 6'h00;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wd        = 32'h0;
    logic [3:0]  be        = 4'h0;
    logic [5:0]  ev        = 6'h00;
    logic        aoff      = 1'b0;
    logic        bloff     = 1'b0;
    logic        rcp       = 1'b0;
    logic [31:0] rdat;
    logic        wreq;
    logic [47:0] tnow;
    logic        tld;
    logic        irq;
    int          error_cnt = 0;
    int          checked   = 0;
    int          loads     = 0;
    int          ops [8]   = '{1, 2, 1, 0, 2, 3, 1, 3};
    int          g;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (tld === 1'b1) loads++;

    hsc_top #(.ADDR_W(6)) uut (
        .i_clk(clk),              .i_rst_b(rst_b),
        .i_avs_address(adr),      .i_avs_read(rd),
        .i_avs_write(wr),         .i_avs_writedata(wd),
        .i_avs_byteenable(be),    .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_num_start(ev[0]),
        .i_num_done(ev[1]),       .i_num_cancel(ev[2]),
        .i_txt_start(ev[3]),      .i_txt_done(ev[4]),
        .i_txt_cancel(ev[5]),     .i_autooff_en(aoff),
        .i_backlight_off(bloff),  .i_recipe_busy(rcp),
        .o_time_now(tnow),        .o_time_loaded(tld),
        .o_irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low; one idle cycle after
    task automatic xfer(input logic r, input logic [5:0] a,
                        input logic [15:0] d, input logic [3:0] b,
                        output logic [31:0] q);
        int n;
        @(posedge clk);
        rd  <= r;
        wr  <= !r;
        adr <= a;
        wd  <= {16'h0000, d};
        be  <= b;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            $display("Error at %0t: bus answer never came", $time);
            complete_run();
        end
    endtask

    task automatic bus_wr(input logic [5:0] a, input logic [15:0] d,
                          input logic [3:0] b);
        logic [31:0] q;
        xfer(1'b0, a, d, b, q);
    endtask

    task automatic bus_rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b1, a, 16'h0000, 4'hF, q);
        chk({16'h0000, q}, {16'h0000, e});
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        bus_rd(6'h0C, 32'h0);
        bus_rd(6'h10, 32'h0);
        bus_rd(6'h1C, 32'h0);
        chk(tnow, HSC_TIME_RST);
        // Unmapped and read-only places swallow writes
        bus_wr(6'h08, 16'hFFFF, 4'h3);
        bus_rd(6'h08, 32'h0);
        bus_wr(6'h0C, 16'hFFFF, 4'h3);
        bus_rd(6'h0C, 32'h0);
        // Entry flags of both kinds, step table
        for (g = 0; g < 2; g++) begin
            foreach (ops[i]) begin
                if (ops[i] == 3) begin
                    bus_wr(6'h04, g ? 16'h0800 : 16'h0400, 4'h2);
                end else begin
                    pulse(3 * g + ops[i]);
                end
                bus_rd(6'h0C, ((ops[i] == 1) ? 32'h1 : (ops[i] == 2) ?
                       32'h2 : 32'h0) << (5 * g));
            end
        end
        pulse(1);
        pulse(4);
        bus_wr(6'h04, 16'h0400, 4'h2);
        bus_rd(6'h0C, 32'h20);
        bus_wr(6'h04, 16'h0800, 4'h2);
        // Live level bits
        @(posedge clk);
        aoff  <= 1'b1;
        bloff <= 1'b1;
        rcp   <= 1'b1;
        bus_rd(6'h0C, 32'h14);
        @(posedge clk);
        aoff <= 1'b0;
        rcp  <= 1'b0;
        bus_rd(6'h0C, 32'h0);
        // Staging, then whole commit
        bus_wr(6'h10, 16'h2412, 4'h3);
        bus_wr(6'h14, 16'h3123, 4'h3);
        bus_wr(6'h18, 16'h5959, 4'h3);
        bus_wr(6'h18, 16'h0700, 4'h2);
        bus_rd(6'h18, 32'h0759);
        bus_rd(6'h14, 32'h3123);
        chk(tnow, HSC_TIME_RST);
        bus_wr(6'h1C, 16'h8000, 4'h3);
        repeat (3) @(posedge clk);
        chk(tnow, 48'h2412_3123_0759);
        chk(48'(loads), 48'd1);
        bus_wr(6'h10, 16'h9901, 4'h3);
        bus_wr(6'h1C, 16'h0000, 4'h3);
        repeat (3) @(posedge clk);
        chk(tnow, 48'h2412_3123_0759);
        bus_rd(6'h1C, 32'h0);
        bus_wr(6'h1C, 16'h8000, 4'h3);
        repeat (3) @(posedge clk);
        chk(tnow, 48'h9901_3123_0759);
        chk(48'(loads), 48'd2);
        // Interrupt: raise, mask, clear
        bus_rd(6'h20, 32'h3F);
        bus_wr(6'h20, 16'h003F, 4'h1);
        bus_rd(6'h20, 32'h0);
        bus_wr(6'h24, 16'h0001, 4'h1);
        pulse(1);
        @(posedge clk);
        chk({47'h0, irq}, 48'h1);
        pulse(5);
        bus_rd(6'h20, 32'h21);
        bus_wr(6'h20, 16'h0001, 4'h1);
        @(posedge clk);
        chk({47'h0, irq}, 48'h0);
        bus_wr(6'h24, 16'h0020, 4'h1);
        @(posedge clk);
        chk({47'h0, irq}, 48'h1);
        bus_wr(6'h20, 16'h0020, 4'h1);
        @(posedge clk);
        chk({47'h0, irq}, 48'h0);
        bus_rd(6'h24, 32'h20);
        complete_run();
    end
endmodule

// >>> verif/hsc_top_chk.sv
// Port assertions for the status and clock-set register bank.
// Assumes one clock; bound into hsc_top by the statement at the foot.
`timescale 1ns/1ps
module hsc_top_chk
    import hsc_pkg::*;
#(
    parameter int unsigned ADDR_W = 6
)
(
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire logic [ADDR_W-1:0]     i_avs_address,
    input wire logic                  i_avs_read,
    input wire logic                  i_avs_write,
    input wire logic [HSC_DATA_W-1:0] i_avs_writedata,
    input wire logic [HSC_BE_W-1:0]   i_avs_byteenable,
    input wire logic [HSC_DATA_W-1:0] o_avs_readdata,
    input wire logic                  o_avs_waitrequest,
    input wire logic                  i_num_start,
    input wire logic                  i_num_done,
    input wire logic                  i_num_cancel,
    input wire logic                  i_txt_start,
    input wire logic                  i_txt_done,
    input wire logic                  i_txt_cancel,
    input wire logic                  i_autooff_en,
    input wire logic                  i_backlight_off,
    input wire logic                  i_recipe_busy,
    input wire logic [47:0]           o_time_now,
    input wire logic                  o_time_loaded,
    input wire logic                  o_irq
);
    wire logic acc_w   = i_avs_write && !o_avs_waitrequest;
    wire logic rd_st   = i_avs_read && o_avs_waitrequest
                         && i_avs_address == ADDR_W'(8'h0C);
    wire logic clr_num = acc_w && i_avs_address == ADDR_W'(8'h04)
                         && i_avs_byteenable[1] && i_avs_writedata[10];
    wire logic clr_txt = acc_w && i_avs_address == ADDR_W'(8'h04)
                         && i_avs_byteenable[1] && i_avs_writedata[11];
    wire logic commit  = acc_w && i_avs_address == ADDR_W'(8'h1C)
                         && i_avs_byteenable[1] && i_avs_writedata[15];
    wire logic bl_live = i_autooff_en && i_backlight_off;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Status read issued two cycles after a cause; the cycle between is not checked
    sequence after_s(cause);
        cause ##2 rd_st;
    endsequence

    one_wait_a: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Request waited more than one cycle");
    resv_zero_a: assert property (
        rd_st |=> o_avs_readdata[15:7] == 9'h000 && !o_avs_readdata[3])
        else $error("Reserved status bit reads one");
    live_bits_a: assert property (
        rd_st |=> o_avs_readdata[2] == $past(bl_live)
                  && o_avs_readdata[4] == $past(i_recipe_busy))
        else $error("Live status bits wrong");
    num_done_a: assert property (
        after_s(i_num_done) |=> o_avs_readdata[1:0] == 2'h1)
        else $error("Numeric done flags wrong");
    num_cancel_a: assert property (
        after_s(i_num_cancel) |=> o_avs_readdata[1:0] == 2'h2)
        else $error("Numeric cancel flags wrong");
    txt_done_a: assert property (
        after_s(i_txt_done) |=> o_avs_readdata[6:5] == 2'h1)
        else $error("Text done flags wrong");
    txt_cancel_a: assert property (
        after_s(i_txt_cancel) |=> o_avs_readdata[6:5] == 2'h2)
        else $error("Text cancel flags wrong");
    num_clear_a: assert property (
        after_s(clr_num) |=> o_avs_readdata[1:0] == 2'h0)
        else $error("Numeric flags not cleared");
    txt_clear_a: assert property (
        after_s(clr_txt) |=> o_avs_readdata[6:5] == 2'h0)
        else $error("Text flags not cleared");
    commit_load_a: assert property (
        commit |-> ##2 o_time_loaded)
        else $error("Commit did not load the clock");
    load_cause_a: assert property (
        o_time_loaded |-> $past(commit, 2))
        else $error("Clock load without a commit");
    time_hold_a: assert property (
        $changed(o_time_now) |-> o_time_loaded)
        else $error("Clock changed without a commit");
endmodule

bind hsc_top hsc_top_chk #(.ADDR_W(ADDR_W)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_num_start(i_num_start), .i_num_done(i_num_done),
    .i_num_cancel(i_num_cancel), .i_txt_start(i_txt_start),
    .i_txt_done(i_txt_done), .i_txt_cancel(i_txt_cancel),
    .i_autooff_en(i_autooff_en), .i_backlight_off(i_backlight_off),
    .i_recipe_busy(i_recipe_busy), .o_time_now(o_time_now),
    .o_time_loaded(o_time_loaded), .o_irq(o_irq)
);
